// *** core/tiop_defines.vh ***
// Purpose: shared constants of the timed io port logic
// Assumes: one clock, mclk_i at 40 MHz
// Notes: width codes select the nominal port width
`ifndef TIOP_DEFINES_VH
`define TIOP_DEFINES_VH
`define TIOP_W1 3'h0
`define TIOP_W4 3'h1
`define TIOP_W8 3'h2
`define TIOP_W16 3'h3
`define TIOP_W32 3'h4
`define TIOP_COND_NONE 2'h0
`define TIOP_COND_EQ 2'h1
`define TIOP_COND_NE 2'h2
`define TIOP_NUM_CB 6
`define TIOP_CB_RST 3'h0
`define TIOP_CNT_RST 16'h0000
`define TIOP_PULL_RST 32'hffffffff
`endif

// *** core/tiop_buf2.v ***
// Purpose: two-entry word buffer with valid and ready on both sides
// Assumes: synchronous use on mclk_i
// Notes: read data come straight from a register
`timescale 1ns/10ps
module tiop_buf2 #(
   parameter DW = 32
) (
   input wire mclk_i, // clock
   input wire rst_i, // async reset, high
   input wire wr_valid_i, // word offered
   input wire [DW-1:0] wr_data_i, // offered word
   output reg wr_ready_o, // room for a word
   output reg rd_valid_o, // head word valid
   output reg [DW-1:0] rd_data_o, // head word
   input wire rd_ready_i // head word taken
);
   reg [DW-1:0] tail_q;
   reg [1:0] cnt_q;
   reg [1:0] cnt_d;
   wire push = wr_valid_i && wr_ready_o;
   wire pop = rd_valid_o && rd_ready_i;
   always @* begin
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + 2'h1;
      else if (pop && !push)
         cnt_d = cnt_q - 2'h1;
   end
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 2'h0;
         tail_q <= {DW{1'b0}};
         rd_data_o <= {DW{1'b0}};
         rd_valid_o <= 1'b0;
         wr_ready_o <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         rd_valid_o <= (cnt_d != 2'h0);
         wr_ready_o <= (cnt_d != 2'h2);
         if (pop) begin
            if (cnt_q == 2'h2) begin
               rd_data_o <= tail_q;
               if (push)
                  tail_q <= wr_data_i;
            end else if (push) begin
               rd_data_o <= wr_data_i;
            end
         end else if (push) begin
            if (cnt_q == 2'h0)
               rd_data_o <= wr_data_i;
            else
               tail_q <= wr_data_i;
         end
      end
   end
endmodule

// *** core/tiop_port.v ***
// Purpose: one timed io port with clock blocks, serialiser and counter
// Assumes: all inputs synchronous to mclk_i
// Notes: clock block 0 ticks every mclk_i cycle as the reference
`timescale 1ns/10ps
`include "tiop_defines.vh"
module tiop_port #(
   parameter NPIN = 32,
   parameter DIVW = 8
) (
   input wire mclk_i, // 40 MHz clock
   input wire rst_i, // async reset, high
   input wire cfg_we_i, // load port configuration
   input wire cfg_en_i, // port enabled
   input wire cfg_out_i, // 1 output, 0 input
   input wire [2:0] cfg_width_i, // width code
   input wire cfg_od_i, // open-drain select
   input wire [2:0] cfg_cb_i, // clock block select
   input wire cfg_strb_in_i, // honour incoming strobe
   input wire cfg_strb_out_i, // drive outgoing strobe
   input wire [1:0] cond_mode_i, // input wait condition
   input wire [31:0] cond_val_i, // condition value
   input wire time_en_i, // wait for counter match
   input wire [15:0] time_val_i, // counter match value
   input wire cb_we_i, // load a clock block
   input wire [2:0] cb_idx_i, // clock block index 1..5
   input wire cb_ext_i, // source is external pin
   input wire [DIVW-1:0] cb_div_i, // divide by value+1
   input wire ext_clk_i, // external clock from 1-bit port
   input wire pull_we_i, // software pull write
   input wire [NPIN-1:0] pull_val_i, // pull enables
   input wire link_en_i, // link enabled
   input wire [NPIN-1:0] link_pins_i, // pins under link
   input wire [NPIN-1:0] narrow_pins_i, // pins of narrower ports
   input wire [NPIN-1:0] pin_i, // pin levels
   output reg [NPIN-1:0] pin_o, // pin drive values
   output reg [NPIN-1:0] pin_oe_o, // pin drive enables
   output reg [NPIN-1:0] pull_en_o, // weak pull enables
   input wire strobe_from_outside_i, // external strobe
   output reg strobe_to_outside_o, // strobe with output data
   input wire tx_valid_i, // word from processor
   input wire [31:0] tx_data_i, // word to send
   output wire tx_ready_o, // word taken
   output wire rx_valid_o, // word to processor
   output wire [31:0] rx_data_o, // received word
   input wire rx_ready_i, // processor took word
   output reg [15:0] count_o, // port counter
   output reg [15:0] stamp_o, // last transfer timestamp
   output reg event_o // pin event pulse
);
   localparam S_IDLE = 2'h0;
   localparam S_WAIT = 2'h1;
   localparam S_SHIFT = 2'h2;
   localparam S_PUSH = 2'h3;

   reg en_q;
   reg out_q;
   reg od_q;
   reg sin_q;
   reg sout_q;
   reg [2:0] wcode_q;
   reg [2:0] cb_q;
   reg [1:0] st_q;
   reg [31:0] xfer_q;
   reg [5:0] beat_q;
   reg [NPIN-1:0] drv_q;
   reg ext_q;
   reg strb_q;
   reg [NPIN-1:0] pin_ok;
   wire [`TIOP_NUM_CB-1:0] tick;
   wire ext_rise = ext_clk_i && !ext_q;

   // nominal width in bits per beat
   function [5:0] wbits;
      input [2:0] c;
      begin
         case (c)
            `TIOP_W1: wbits = 6'd1;
            `TIOP_W4: wbits = 6'd4;
            `TIOP_W8: wbits = 6'd8;
            `TIOP_W16: wbits = 6'd16;
            default: wbits = 6'd32;
         endcase
      end
   endfunction

   function [31:0] wmask;
      input [2:0] c;
      begin
         case (c)
            `TIOP_W1: wmask = 32'h00000001;
            `TIOP_W4: wmask = 32'h0000000f;
            `TIOP_W8: wmask = 32'h000000ff;
            `TIOP_W16: wmask = 32'h0000ffff;
            default: wmask = 32'hffffffff;
         endcase
      end
   endfunction

   // gather lsb-first: new sample enters at the top
   function [31:0] gather;
      input [2:0] c;
      input [31:0] x;
      input [31:0] p;
      begin
         case (c)
            `TIOP_W1: gather = {p[0], x[31:1]};
            `TIOP_W4: gather = {p[3:0], x[31:4]};
            `TIOP_W8: gather = {p[7:0], x[31:8]};
            `TIOP_W16: gather = {p[15:0], x[31:16]};
            default: gather = p;
         endcase
      end
   endfunction

   function [31:0] shout;
      input [2:0] c;
      input [31:0] x;
      begin
         case (c)
            `TIOP_W1: shout = {1'b0, x[31:1]};
            `TIOP_W4: shout = {4'h0, x[31:4]};
            `TIOP_W8: shout = {8'h00, x[31:8]};
            `TIOP_W16: shout = {16'h0000, x[31:16]};
            default: shout = 32'h00000000;
         endcase
      end
   endfunction

   // clock blocks: 0 is the reference, 1..5 programmable
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i)
         ext_q <= 1'b0;
      else
         ext_q <= ext_clk_i;
   end

   assign tick[0] = 1'b1;

   genvar g;
   generate
      for (g = 1; g < `TIOP_NUM_CB; g = g + 1) begin : cblk
         reg src_q;
         reg [DIVW-1:0] div_q;
         reg [DIVW-1:0] cnt_q;
         reg tk_q;
         wire edge_in = src_q ? ext_rise : 1'b1;
         always @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               src_q <= 1'b0;
               div_q <= {DIVW{1'b0}};
               cnt_q <= {DIVW{1'b0}};
               tk_q <= 1'b0;
            end else begin
               tk_q <= 1'b0;
               if (cb_we_i && cb_idx_i == g) begin
                  src_q <= cb_ext_i;
                  div_q <= cb_div_i;
                  cnt_q <= {DIVW{1'b0}};
               end else if (edge_in) begin
                  if (cnt_q == div_q) begin
                     cnt_q <= {DIVW{1'b0}};
                     tk_q <= 1'b1;
                  end else begin
                     cnt_q <= cnt_q + {{(DIVW-1){1'b0}}, 1'b1};
                  end
               end
            end
         end
         assign tick[g] = tk_q;
      end
   endgenerate

   wire ptick = (cb_q < `TIOP_NUM_CB) ? tick[cb_q] : 1'b0;
   wire strb_ok = !sin_q || strobe_from_outside_i;
   wire [31:0] mask = wmask(wcode_q);
   wire [31:0] pins_w = pin_i & mask;
   // pins owned under the width being written
   wire [31:0] new_mask = wmask(cfg_width_i);

   // pin ownership: link and narrower ports win their pins
   always @* begin
      pin_ok = mask[NPIN-1:0] & ~narrow_pins_i;
      if (link_en_i)
         pin_ok = pin_ok & ~link_pins_i;
   end

   // processor side buffers
   wire tq_valid;
   wire [31:0] tq_data;
   reg tq_take;
   wire rq_ready;
   reg rq_push;
   tiop_buf2 #(.DW(32)) u_txbuf (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .wr_valid_i(tx_valid_i),
      .wr_data_i(tx_data_i),
      .wr_ready_o(tx_ready_o),
      .rd_valid_o(tq_valid),
      .rd_data_o(tq_data),
      .rd_ready_i(tq_take)
   );
   tiop_buf2 #(.DW(32)) u_rxbuf (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .wr_valid_i(rq_push),
      .wr_data_i(xfer_q),
      .wr_ready_o(rq_ready),
      .rd_valid_o(rx_valid_o),
      .rd_data_o(rx_data_o),
      .rd_ready_i(rx_ready_i)
   );

   // wait conditions
   reg cond_ok;
   always @* begin
      case (cond_mode_i)
         `TIOP_COND_EQ: cond_ok = (pins_w == (cond_val_i & mask));
         `TIOP_COND_NE: cond_ok = (pins_w != (cond_val_i & mask));
         default: cond_ok = 1'b1;
      endcase
   end
   wire time_ok = !time_en_i || (count_o == time_val_i);
   wire go = ptick && time_ok && (out_q || cond_ok);

   always @* begin
      tq_take = en_q && out_q && st_q == S_IDLE;
      rq_push = st_q == S_PUSH;
   end

   // configuration
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         en_q <= 1'b0;
         out_q <= 1'b0;
         od_q <= 1'b0;
         sin_q <= 1'b0;
         sout_q <= 1'b0;
         wcode_q <= `TIOP_W1;
         cb_q <= `TIOP_CB_RST;
      end else if (cfg_we_i) begin
         en_q <= cfg_en_i;
         out_q <= cfg_out_i;
         od_q <= cfg_od_i;
         sin_q <= cfg_strb_in_i;
         sout_q <= cfg_strb_out_i;
         wcode_q <= (cfg_width_i > `TIOP_W32) ? `TIOP_W32 : cfg_width_i;
         cb_q <= cfg_cb_i;
      end
   end

   // port counter
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i)
         count_o <= `TIOP_CNT_RST;
      else if (ptick)
         count_o <= count_o + 16'h0001;
   end

   // transfer sequence
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= S_IDLE;
         xfer_q <= 32'h00000000;
         beat_q <= 6'h00;
         drv_q <= {NPIN{1'b0}};
         stamp_o <= 16'h0000;
         event_o <= 1'b0;
         strb_q <= 1'b0;
      end else begin
         event_o <= 1'b0;
         if (ptick)
            strb_q <= 1'b0;
         if (!en_q || cfg_we_i) begin
            st_q <= S_IDLE;
            strb_q <= 1'b0;
         end else begin
            case (st_q)
               S_IDLE: begin
                  beat_q <= 6'h00;
                  if (out_q) begin
                     if (tq_valid) begin
                        xfer_q <= tq_data;
                        st_q <= S_WAIT;
                     end
                  end else begin
                     st_q <= S_WAIT;
                  end
               end
               S_WAIT: begin
                  if (go && strb_ok) begin
                     stamp_o <= count_o;
                     st_q <= S_SHIFT;
                     if (!out_q && cond_mode_i != `TIOP_COND_NONE)
                        event_o <= 1'b1;
                  end
               end
               S_SHIFT: begin
                  if (ptick && strb_ok) begin
                     beat_q <= beat_q + wbits(wcode_q);
                     if (out_q) begin
                        drv_q <= xfer_q[NPIN-1:0] & mask[NPIN-1:0];
                        xfer_q <= shout(wcode_q, xfer_q);
                        strb_q <= sout_q;
                     end else begin
                        xfer_q <= gather(wcode_q, xfer_q, pins_w);
                     end
                     if (beat_q + wbits(wcode_q) >= 6'd32) begin
                        st_q <= out_q ? S_IDLE : S_PUSH;
                        if (out_q)
                           event_o <= 1'b1;
                     end
                  end
               end
               S_PUSH: begin
                  if (rq_ready) begin
                     st_q <= S_IDLE;
                     event_o <= 1'b1;
                  end
               end
               default: st_q <= S_IDLE;
            endcase
         end
      end
   end

   // pin drive, open drain and pulls
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_o <= {NPIN{1'b0}};
         pin_oe_o <= {NPIN{1'b0}};
         pull_en_o <= `TIOP_PULL_RST;
         strobe_to_outside_o <= 1'b0;
      end else begin
         // strobe rides with the beat on the pins
         strobe_to_outside_o <= strb_q;
         if (en_q && out_q) begin
            pin_o <= od_q ? {NPIN{1'b0}} : drv_q;
            pin_oe_o <= od_q ? (pin_ok & ~drv_q) : pin_ok;
         end else begin
            pin_o <= {NPIN{1'b0}};
            pin_oe_o <= {NPIN{1'b0}};
         end
         if (pull_we_i)
            pull_en_o <= pull_val_i;
         else if (cfg_we_i && cfg_en_i)
            pull_en_o <= pull_en_o & ~(new_mask[NPIN-1:0] & ~narrow_pins_i);
         else if (link_en_i)
            pull_en_o <= pull_en_o & ~link_pins_i;
      end
   end
endmodule

// *** sim/tiop_port_sva.sv ***
// Purpose: port-level checks of the timed io port
// Assumes: bound to every tiop_port
// Notes: mode bits mirror configuration writes
`timescale 1ns/10ps
module tiop_port_sva #(
   parameter NPIN = 32
) (
   input wire mclk_i, // clock
   input wire rst_i, // reset
   input wire cfg_we_i, // cfg load
   input wire cfg_out_i, // direction
   input wire cfg_od_i, // open drain
   input wire link_en_i, // link on
   input wire [NPIN-1:0] link_pins_i, // link pins
   input wire [NPIN-1:0] narrow_pins_i, // narrow pins
   input wire [NPIN-1:0] pin_o, // drive
   input wire [NPIN-1:0] pin_oe_o, // enables
   input wire [NPIN-1:0] pull_en_o, // pulls
   input wire rx_valid_o, // rx valid
   input wire [31:0] rx_data_o, // rx word
   input wire rx_ready_i, // rx taken
   input wire [15:0] count_o, // counter
   input wire [15:0] stamp_o, // stamp
   input wire event_o // event
);
   reg out_q;
   reg od_q;
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         out_q <= 1'b0;
         od_q <= 1'b0;
      end else if (cfg_we_i) begin
         out_q <= cfg_out_i;
         od_q <= cfg_od_i;
      end
   end
   default clocking dc @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence to_input;
      cfg_we_i && !cfg_out_i ##1 !cfg_we_i [*3];
   endsequence
   a_rst_values: assert property ($fell(rst_i) |->
      pull_en_o == '1 && count_o == 16'h0000)
      else $error("reset values wrong");
   a_count_step: assert property (!$stable(count_o) |->
      count_o == $past(count_o) + 16'h0001)
      else $error("counter jumped");
   a_stamp_src: assert property (!$stable(stamp_o) |->
      stamp_o == $past(count_o))
      else $error("stamp not from counter");
   a_input_quiet: assert property (to_input |-> pin_oe_o == '0)
      else $error("input port drives");
   a_link_free: assert property ($past(link_en_i) |->
      (pin_oe_o & $past(link_pins_i)) == '0)
      else $error("link pin driven");
   a_narrow_wins: assert property (
      (pin_oe_o & $past(narrow_pins_i)) == '0)
      else $error("narrow pin driven");
   a_od_low: assert property (od_q && $past(od_q) |->
      (pin_o & pin_oe_o) == '0)
      else $error("open drain drove high");
   a_event_pulse: assert property (event_o |=> !event_o)
      else $error("event longer than a cycle");
   a_rx_hold: assert property (rx_valid_o && !rx_ready_i |=>
      rx_valid_o && $stable(rx_data_o))
      else $error("rx word lost");
endmodule
bind tiop_port tiop_port_sva #(.NPIN(NPIN)) u_sva (.*);

// *** sim/tiop_ext_dev.sv ***
// Purpose: hardware on the far side of the pins
// Assumes: weak pulls pull the pins down
// Notes: a floating pin shows the inverse of the last drive
`timescale 1ns/10ps
module tiop_ext_dev (
   input wire [31:0] pin_o_i, // port drive
   input wire [31:0] oe_i, // port enables
   input wire [31:0] pull_i, // pull enables
   input wire [31:0] lvl_i, // far levels
   input wire [31:0] far_oe_i, // far enables
   output wire [31:0] pin_i_o // wire level
);
   assign pin_i_o = (oe_i & pin_o_i) | (~oe_i & far_oe_i & lvl_i) |
      (~oe_i & ~far_oe_i & ~pull_i & ~pin_o_i);
endmodule

// *** sim/tb.sv ***
// Purpose: self-checking bench of the timed io port
// Assumes: clock block 0 ticks every cycle
// Notes: beat timing follows the port walk
`timescale 1ns/10ps
`include "tiop_defines.vh"
module tb;
   localparam [31:0] W = 32'h9a3c5e71;
   reg mclk_i = 1'b0;
   reg rst_i = 1'b1;
   reg cfg_we_i, cfg_en_i, cfg_out_i, cfg_od_i, cfg_strb_in_i;
   reg cfg_strb_out_i, time_en_i, cb_we_i, cb_ext_i, ext_clk_i;
   reg pull_we_i, link_en_i, strobe_from_outside_i, tx_valid_i;
   reg rx_ready_i;
   reg [2:0] cfg_width_i, cfg_cb_i, cb_idx_i;
   reg [1:0] cond_mode_i;
   reg [7:0] cb_div_i;
   reg [15:0] time_val_i;
   reg [31:0] cond_val_i, pull_val_i, link_pins_i, narrow_pins_i;
   reg [31:0] tx_data_i, lvl, far_oe;
   wire [31:0] pin_i, pin_o, pin_oe_o, pull_en_o, rx_data_o;
   wire strobe_to_outside_o, tx_ready_o, rx_valid_o, event_o;
   wire [15:0] count_o, stamp_o;
   integer err_total = 0;
   integer checks_done = 0;
   reg [1:0] ev_hist = 2'b00;
   tiop_port dut (.*);
   tiop_ext_dev far (.pin_o_i(pin_o), .oe_i(pin_oe_o),
      .pull_i(pull_en_o), .lvl_i(lvl), .far_oe_i(far_oe),
      .pin_i_o(pin_i));
   always #12.5 mclk_i = ~mclk_i;
   always @(negedge mclk_i) ev_hist <= {ev_hist[0], event_o};
   task chk(input [31:0] s, input [31:0] e, input string nm);
      checks_done = checks_done + 1;
      if (s !== e) begin
         err_total = err_total + 1;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge mclk_i);
   endtask
   task cfg(input o, input [2:0] w, input d, input [2:0] c);
      cfg_out_i = o;
      cfg_width_i = w;
      cfg_od_i = d;
      cfg_cb_i = c;
      cfg_we_i = 1'b1;
      cyc(1);
      cfg_we_i = 1'b0;
   endtask
   task send(input [2:0] c, input d, input [31:0] tk);
      integer b, wd;
      reg [31:0] m, bt, eo;
      reg [15:0] cs;
      wd = 1 << ((c == 3'h0) ? 0 : c + 1);
      m = (64'h1 << wd) - 64'h1;
      cfg(1'b1, c, d, `TIOP_CB_RST);
      chk(tx_ready_o, 1'b1, "tx_ready");
      tx_valid_i = 1'b1;
      tx_data_i = W;
      cyc(1);
      cs = count_o + 16'h0001;
      tx_valid_i = 1'b0;
      cyc(4);
      for (b = 0; b < 32 / wd; b = b + 1) begin
         bt = (W >> (b * wd)) & m;
         eo = (d ? ~bt : 32'hffffffff) & m & ~tk;
         chk(pin_oe_o, eo, "pin_oe");
         chk(pin_o & eo, d ? 32'h0 : bt & eo, "pin");
         chk(strobe_to_outside_o, 1'b1, "strobe_out");
         cyc(1);
      end
      chk(ev_hist, 2'b10, "event");
      chk(stamp_o, cs, "stamp");
      cyc(3);
   endtask
   task recv;
      integer i;
      far_oe = 32'hff;
      lvl = 32'h3c;
      cond_mode_i = `TIOP_COND_EQ;
      cond_val_i = 32'h3c;
      cfg_strb_in_i = 1'b1;
      cfg(1'b0, `TIOP_W8, 1'b0, `TIOP_CB_RST);
      cyc(40);
      chk(rx_valid_o, 1'b0, "rx_early");
      chk(pin_oe_o, 32'h0, "in_oe");
      strobe_from_outside_i = 1'b1;
      i = 0;
      while (rx_valid_o !== 1'b1 && i < 100) begin
         cyc(1);
         i = i + 1;
      end
      chk(rx_data_o, 32'h3c3c3c3c, "rx_word");
      cyc(40);
      chk(rx_valid_o, 1'b1, "rx_stall");
      chk(rx_data_o, 32'h3c3c3c3c, "rx_held");
      rx_ready_i = 1'b1;
      cyc(1);
      rx_ready_i = 1'b0;
      chk(rx_valid_o, 1'b1, "rx_second");
   endtask
   task clkblk;
      integer i;
      reg [15:0] c0;
      cond_mode_i = `TIOP_COND_NONE;
      cb_idx_i = 3'h1;
      cb_ext_i = 1'b1;
      cb_div_i = 8'h01;
      cb_we_i = 1'b1;
      cyc(1);
      cb_we_i = 1'b0;
      cfg(1'b0, `TIOP_W1, 1'b0, 3'h1);
      for (i = 0; i < 24; i = i + 1) begin
         if (i == 4) c0 = count_o;
         if (i == 20) chk(count_o - c0, 16'h4, "cb_ticks");
         ext_clk_i = ~ext_clk_i;
         cyc(2);
      end
   endtask
   task tsched;
      reg [15:0] t;
      cond_mode_i = `TIOP_COND_NE;
      cond_val_i = 32'h0;
      cfg(1'b0, `TIOP_W32, 1'b0, `TIOP_CB_RST);
      t = count_o + 16'h0014;
      time_val_i = t;
      time_en_i = 1'b1;
      cyc(30);
      chk(stamp_o, t, "stamp_sched");
      time_en_i = 1'b0;
   endtask
   task summarize;
      if (err_total == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      err_total = err_total + 1;
      summarize;
   end
   initial begin
      integer k;
      reg [15:0] c0;
      {cfg_we_i, cfg_out_i, cfg_od_i, cfg_strb_in_i, time_en_i} = '0;
      {cb_we_i, cb_ext_i, ext_clk_i, pull_we_i, link_en_i} = '0;
      {strobe_from_outside_i, tx_valid_i, rx_ready_i} = '0;
      {cfg_width_i, cfg_cb_i, cb_idx_i, cond_mode_i, cb_div_i} = '0;
      {time_val_i, cond_val_i, pull_val_i, link_pins_i} = '0;
      {narrow_pins_i, tx_data_i, lvl, far_oe} = '0;
      cfg_en_i = 1'b1;
      cfg_strb_out_i = 1'b1;
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i);
      rst_i = 1'b0;
      cyc(2);
      chk(pull_en_o, 32'hffffffff, "pull_rst");
      c0 = count_o;
      cyc(5);
      chk(count_o, c0 + 16'h5, "count");
      for (k = 0; k < 5; k = k + 1) send(k[2:0], 1'b0, 32'h0);
      chk(pull_en_o, 32'h0, "pull_off");
      pull_val_i = 32'h0000ff00;
      pull_we_i = 1'b1;
      cyc(1);
      pull_we_i = 1'b0;
      cyc(1);
      chk(pull_en_o, 32'h0000ff00, "pull_sw");
      send(`TIOP_W4, 1'b1, 32'h0);
      link_en_i = 1'b1;
      link_pins_i = 32'h30;
      narrow_pins_i = 32'h03;
      send(`TIOP_W8, 1'b0, 32'h33);
      link_en_i = 1'b0;
      narrow_pins_i = 32'h0;
      recv;
      tsched;
      clkblk;
      summarize;
   end
endmodule
